//--- common/boot_decode_pkg.sv
// package of constants for boot section address decode
package boot_decode_pkg;
	// variant selection
	localparam logic       VARIANT_32K          = 1'b0;
	localparam logic       VARIANT_64K          = 1'b1;
	// boot start per setting {hi,lo} = 11,10,01,00, 32K variant
	localparam logic [15:0] BOOT_START_32K_11   = 16'h3F00;
	localparam logic [15:0] BOOT_START_32K_10   = 16'h3E00;
	localparam logic [15:0] BOOT_START_32K_01   = 16'h3C00;
	localparam logic [15:0] BOOT_START_32K_00   = 16'h3800;
	localparam logic [15:0] FLASH_END_32K       = 16'h3FFF;
	// boot start per setting, 64K variant
	localparam logic [15:0] BOOT_START_64K_11   = 16'h7E00;
	localparam logic [15:0] BOOT_START_64K_10   = 16'h7C00;
	localparam logic [15:0] BOOT_START_64K_01   = 16'h7800;
	localparam logic [15:0] BOOT_START_64K_00   = 16'h7000;
	localparam logic [15:0] FLASH_END_64K       = 16'h7FFF;
	// boot sizes in words
	localparam logic [15:0] BOOT_WORDS_32K_11   = 16'h0100;
	localparam logic [15:0] BOOT_WORDS_32K_10   = 16'h0200;
	localparam logic [15:0] BOOT_WORDS_32K_01   = 16'h0400;
	localparam logic [15:0] BOOT_WORDS_32K_00   = 16'h0800;
	localparam logic [15:0] BOOT_WORDS_64K_11   = 16'h0200;
	localparam logic [15:0] BOOT_WORDS_64K_10   = 16'h0400;
	localparam logic [15:0] BOOT_WORDS_64K_01   = 16'h0800;
	localparam logic [15:0] BOOT_WORDS_64K_00   = 16'h1000;
	// read-while-write boundary, same for both variants
	localparam logic [15:0] STALLED_REGION_START = 16'h3800;
	// bytes per word
	localparam int          BYTES_PER_WORD      = 2;
	// pointer field positions, 32K variant
	localparam int          WORD_LSB            = 1;
	localparam int          WORD_MSB_32K        = 6;
	localparam int          PAGE_LSB_32K        = 7;
	localparam int          PAGE_MSB_32K        = 14;
	// pointer field positions, 64K variant (page field as printed, overlaps Z7)
	localparam int          WORD_MSB_64K        = 7;
	localparam int          PAGE_LSB_64K        = 7;
	localparam int          PAGE_MSB_64K        = 15;
	// reset value of boot setting (largest section, safest)
	localparam logic [1:0]  BOOT_SEL_RESET      = 2'h0;
endpackage : boot_decode_pkg

//--- src/boot_size_table.sv
`timescale 1ns/1ps
// boot size table lookup: setting and variant to start and size
module boot_size_table (
	input  wire logic        i_variant,
	input  wire logic [1:0]  i_sel,
	output logic      [15:0] o_start,
	output logic      [15:0] o_words,
	output logic      [15:0] o_end
);
	// pure table, registered by the caller
	always_comb begin
		o_end = (i_variant == boot_decode_pkg::VARIANT_64K) ? boot_decode_pkg::FLASH_END_64K
			: boot_decode_pkg::FLASH_END_32K;
		unique case ({i_variant, i_sel})
			3'h3: begin
				o_start = boot_decode_pkg::BOOT_START_32K_11;
				o_words = boot_decode_pkg::BOOT_WORDS_32K_11;
			end
			3'h2: begin
				o_start = boot_decode_pkg::BOOT_START_32K_10;
				o_words = boot_decode_pkg::BOOT_WORDS_32K_10;
			end
			3'h1: begin
				o_start = boot_decode_pkg::BOOT_START_32K_01;
				o_words = boot_decode_pkg::BOOT_WORDS_32K_01;
			end
			3'h0: begin
				o_start = boot_decode_pkg::BOOT_START_32K_00;
				o_words = boot_decode_pkg::BOOT_WORDS_32K_00;
			end
			3'h7: begin
				o_start = boot_decode_pkg::BOOT_START_64K_11;
				o_words = boot_decode_pkg::BOOT_WORDS_64K_11;
			end
			3'h6: begin
				o_start = boot_decode_pkg::BOOT_START_64K_10;
				o_words = boot_decode_pkg::BOOT_WORDS_64K_10;
			end
			3'h5: begin
				o_start = boot_decode_pkg::BOOT_START_64K_01;
				o_words = boot_decode_pkg::BOOT_WORDS_64K_01;
			end
			3'h4: begin
				o_start = boot_decode_pkg::BOOT_START_64K_00;
				o_words = boot_decode_pkg::BOOT_WORDS_64K_00;
			end
		endcase
	end
endmodule : boot_size_table

//--- src/boot_section_address_decode.sv
`timescale 1ns/1ps
// boot section, read-while-write and pointer field decode for self-programming
// Overview of operation
// - 32K: settings 11..00 give boot 256..2048 words from 0x3F00..0x3800 to 0x3FFF.
// - 64K: settings give boot 512..4096 words from 0x7E00..0x7000; application below.
// - 32K: words 0x3800-0x3FFF stall reads during writes; lower words do not.
// - 32K: 14-bit counter, 64-word pages, word Z6:Z1, page Z14:Z7.
// - 64K: 15-bit counter, 128-word pages, word Z7:Z1, page Z15:Z7 as printed.
// - counter bit n maps to pointer bit n+1; pointer bit zero is not part of the word address.
// - pointer bit zero selects the byte of a load; stores need it zero.
// - page field picks erase/write page; word field picks buffer word.
// - boundaries and sizes count 16-bit words of two bytes.
module boot_section_address_decode #(
	parameter logic VARIANT = boot_decode_pkg::VARIANT_32K
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_boot_size_sel_hi,
	input  wire logic        i_boot_size_sel_lo,
	input  wire logic [15:0] i_pointer,
	input  wire logic        i_store_req,
	input  wire logic        i_page_write,
	input  wire logic        i_load_req,
	output logic      [15:0] o_boot_start,
	output logic      [15:0] o_app_end,
	output logic      [15:0] o_boot_words,
	output logic      [16:0] o_boot_bytes,
	output logic      [15:0] o_word_addr,
	output logic      [8:0]  o_page_select_field,
	output logic      [6:0]  o_word_select_field,
	output logic             o_byte_select,
	output logic             o_in_boot,
	output logic             o_stalled_read_region,
	output logic             o_concurrent_read_region,
	output logic             o_store_valid,
	output logic             o_store_misaligned,
	output logic             o_page_write_offset_err,
	output logic             o_load_valid
);
	// width of program counter and page-word field per variant
	localparam int CTR_W  = (VARIANT == boot_decode_pkg::VARIANT_64K) ? 15 : 14;
	localparam int WORD_W = (VARIANT == boot_decode_pkg::VARIANT_64K) ? 7 : 6;
	localparam int SEL_W  = 2; // one hi and one lo setting pin

	// timing seen by the core:
	// - every output is a flop, so each answer trails its request by one edge
	// - the setting pins pass two flops, then are frozen at the first edge
	//   after reset release; boundaries are valid from the second edge on
	// - requests earlier than the second edge after release are not echoed
	//   on the valid strobes, because the section table is not settled yet
	// - misuse (odd pointer on a store, nonzero word on a page write) is
	//   flagged for one cycle but never blocked; the core owns the policy
	// - pointer bits above the counter width are dropped from the word address,
	//   so an address beyond the flash folds back rather than saturating
	// - the region split is fixed, the boot section is not: both are decoded
	//   from the same word address so their flags always line up

	// fuse pins are static straps but still come from outside: two flops
	logic [1:0]  sel_meta_reg;
	logic [1:0]  sel_sync_reg;
	logic [1:0]  sel_pins;
	logic        sampled_reg;
	logic [1:0]  boot_sel_reg;
	logic [15:0] tbl_start;
	logic [15:0] tbl_words;
	logic [15:0] tbl_end;
	logic [15:0] word_addr;
	logic [8:0]  page_field;
	logic [6:0]  word_field;

	// setting pins gathered into one vector, hi pin on top
	assign sel_pins = {i_boot_size_sel_hi, i_boot_size_sel_lo};

	// synchroniser for the setting pins, one flop pair per pin
	// deliberately not reset: the pins must already be through both flops
	// while reset is held, or the sample at the first edge after release
	// would read cleared flops and every part would boot with setting 00
	for (genvar sel_bit = 0; sel_bit < SEL_W; sel_bit++) begin : g_sel_sync
		always_ff @(posedge i_clk) begin
			sel_meta_reg[sel_bit] <= sel_pins[sel_bit];
			sel_sync_reg[sel_bit] <= sel_meta_reg[sel_bit];
		end
	end

	// latch once after reset release; later pin motion is ignored
	// freezing here, rather than decoding the live pins, keeps a bouncing
	// strap from moving the boot vector under running code
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sampled_reg  <= 1'b0;
			boot_sel_reg <= boot_decode_pkg::BOOT_SEL_RESET;
		end else if (!sampled_reg) begin
			sampled_reg  <= 1'b1;
			boot_sel_reg <= sel_sync_reg;
		end
	end

	// start, size and last word of the boot section for the frozen setting;
	// the table is pure logic and its results are registered below
	boot_size_table u_table (
		.i_variant (VARIANT),
		.i_sel     (boot_sel_reg),
		.o_start   (tbl_start),
		.o_words   (tbl_words),
		.o_end     (tbl_end)
	);

	// stalled region is a fixed boundary, so the two region flags are exact
	// complements; one helper keeps them from drifting apart
	function automatic logic in_stalled_region(input logic [15:0] addr);
		return addr >= boot_decode_pkg::STALLED_REGION_START;
	endfunction : in_stalled_region

	// inclusive span test used for the boot section
	function automatic logic in_span(input logic [15:0] addr, input logic [15:0] first, input logic [15:0] last);
		return (addr >= first) && (addr <= last);
	endfunction : in_span

	// pointer bit n+1 carries counter bit n; bits above the counter drop out
	always_comb begin
		word_addr            = 16'h0000;
		word_addr[CTR_W-1:0] = i_pointer[CTR_W:1];
	end

	// page and word fields sit at different places on the two sizes, so the
	// split is chosen at elaboration and the unused upper field bits are zero
	if (VARIANT == boot_decode_pkg::VARIANT_64K) begin : g_fields_64k
		// page field taken as printed, so Z7 lands in both fields
		always_comb begin
			page_field = i_pointer[boot_decode_pkg::PAGE_MSB_64K:boot_decode_pkg::PAGE_LSB_64K];
			word_field = i_pointer[boot_decode_pkg::WORD_MSB_64K:boot_decode_pkg::WORD_LSB];
		end
	end else begin : g_fields_32k
		// top bits of both fields stay zero on the smaller part
		always_comb begin
			page_field      = 9'h000;
			word_field      = 7'h00;
			page_field[7:0] = i_pointer[boot_decode_pkg::PAGE_MSB_32K:boot_decode_pkg::PAGE_LSB_32K];
			word_field[5:0] = i_pointer[boot_decode_pkg::WORD_MSB_32K:boot_decode_pkg::WORD_LSB];
		end
	end

	// section boundaries, held constant after the sample
	// the application owns every word below the boot start; the byte count
	// is one bit wider than the word count so the largest section still fits
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_boot_start <= 16'h0000;
			o_app_end    <= 16'h0000;
			o_boot_words <= 16'h0000;
			o_boot_bytes <= 17'h00000;
		end else begin
			o_boot_start <= tbl_start;
			o_app_end    <= tbl_start - 16'h0001;
			o_boot_words <= tbl_words;
			o_boot_bytes <= 17'(tbl_words * boot_decode_pkg::BYTES_PER_WORD);
		end
	end

	// per-access address and field decode, one cycle of latency
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_word_addr         <= 16'h0000;
			o_page_select_field <= 9'h000;
			o_word_select_field <= 7'h00;
			o_byte_select       <= 1'b0;
		end else begin
			o_word_addr         <= word_addr;
			o_page_select_field <= page_field;
			o_word_select_field <= word_field;
			o_byte_select       <= i_pointer[0];
		end
	end

	// per-access section and region flags, aligned with o_word_addr
	// the region split does not move with the boot size, so a small boot
	// section still leaves application pages in the stalled region
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_in_boot                <= 1'b0;
			o_stalled_read_region    <= 1'b0;
			o_concurrent_read_region <= 1'b0;
		end else begin
			o_in_boot                <= in_span(word_addr, tbl_start, tbl_end);
			o_stalled_read_region    <= in_stalled_region(word_addr);
			o_concurrent_read_region <= !in_stalled_region(word_addr);
		end
	end

	// store strobes; misuse is flagged, not blocked, so the core decides
	// the misuse flags are not gated by the sample: a bad pointer is bad
	// whatever the section table says
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_store_valid           <= 1'b0;
			o_store_misaligned      <= 1'b0;
			o_page_write_offset_err <= 1'b0;
		end else begin
			o_store_valid           <= i_store_req && sampled_reg;
			o_store_misaligned      <= i_store_req && i_pointer[0];
			o_page_write_offset_err <= i_store_req && i_page_write && (word_field != 7'h00);
		end
	end

	// load strobe; the byte half is chosen by the core from o_byte_select
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_load_valid <= 1'b0;
		end else begin
			o_load_valid <= i_load_req && sampled_reg;
		end
	end

	// only the two flash sizes have a decode table; refuse anything else
	if (CTR_W != 14 && CTR_W != 15) begin : g_bad_counter
		$error("unsupported program counter width");
	end
	if (CTR_W - WORD_W != 8) begin : g_bad_page
		$error("page field does not fit the counter");
	end
endmodule : boot_section_address_decode

//--- test/cpu_core_model.sv
`timescale 1ns/1ps
// core model issuing self-programming stores and program-memory loads
module cpu_core_model (
	input  wire logic        i_clk,
	output logic      [15:0] o_pointer = 16'h0000,
	output logic             o_store_req = 1'h0,
	output logic             o_page_write = 1'h0,
	output logic             o_load_req = 1'h0
);
	// one request per taking edge; no drop between calls, so back to back never double-drives a strobe
	task automatic issue(input logic [15:0] p, input logic s, input logic w, input logic l);
		{o_pointer, o_store_req, o_page_write, o_load_req} = {p, s, w, l};
		@(posedge i_clk);
		#1;
	endtask : issue
endmodule : cpu_core_model

//--- test/boot_decode_asserts.sv
`timescale 1ns/1ps
// checker for boot section and pointer decode
module boot_decode_checker #(
	parameter logic VARIANT = boot_decode_pkg::VARIANT_32K
) (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic [15:0] i_pointer,
	input wire logic        i_store_req,
	input wire logic [15:0] o_boot_start,
	input wire logic [15:0] o_boot_words,
	input wire logic [15:0] o_word_addr,
	input wire logic [8:0]  o_page_select_field,
	input wire logic [6:0]  o_word_select_field,
	input wire logic        o_byte_select,
	input wire logic        o_in_boot,
	input wire logic        o_stalled_read_region,
	input wire logic        o_store_misaligned
);
	localparam logic [15:0] AMASK = VARIANT ? 16'h7FFF : 16'h3FFF;
	localparam logic [6:0]  WMASK = VARIANT ? 7'h7F : 7'h3F;
	localparam logic [16:0] TOP   = VARIANT ? 17'h08000 : 17'h04000;
	logic [1:0] up_reg;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// edges since release; decode is undefined until the setting is sampled
	always_ff @(posedge i_clk) begin
		if (!i_rst_b)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end
	a_word_addr_map: assert property (up_reg == 2'h3 |-> o_word_addr == ({1'h0, $past(i_pointer[15:1])} & AMASK))
		else $error("word address mismatch");
	a_page_field_map: assert property (up_reg == 2'h3 |->
		o_page_select_field == (VARIANT ? $past(i_pointer[15:7]) : {1'h0, $past(i_pointer[14:7])})) else $error("page field");
	a_word_field_map: assert property (up_reg == 2'h3 |-> o_word_select_field == ($past(i_pointer[7:1]) & WMASK))
		else $error("word field");
	a_byte_select_map: assert property (up_reg == 2'h3 |-> o_byte_select == $past(i_pointer[0]))
		else $error("byte select");
	a_region_split: assert property (up_reg == 2'h3 |->
		o_stalled_read_region == (o_word_addr >= boot_decode_pkg::STALLED_REGION_START)) else $error("region split");
	a_boot_span_end: assert property (up_reg == 2'h3 |-> {1'h0, o_boot_start} + {1'h0, o_boot_words} == TOP)
		else $error("boot span");
	a_boot_hold: assert property (up_reg == 2'h3 |=> $stable(o_boot_start) && $stable(o_boot_words))
		else $error("boot moved");
	a_in_boot_flag: assert property (up_reg == 2'h3 |-> o_in_boot == (o_word_addr >= o_boot_start))
		else $error("in boot flag");
	a_misalign_flag: assert property (up_reg == 2'h3 |->
		o_store_misaligned == ($past(i_store_req) && $past(i_pointer[0]))) else $error("misaligned flag");
	c_misaligned: cover property (o_store_misaligned);
	c_in_boot: cover property (o_in_boot);
	c_stalled_app: cover property (o_stalled_read_region && !o_in_boot);
endmodule : boot_decode_checker
bind boot_section_address_decode boot_decode_checker #(.VARIANT(VARIANT)) boot_decode_checker_inst (.i_clk, .i_rst_b,
	.i_pointer, .i_store_req, .o_boot_start, .o_boot_words, .o_word_addr, .o_page_select_field, .o_word_select_field,
	.o_byte_select, .o_in_boot, .o_stalled_read_region, .o_store_misaligned);

//--- test/testbench.sv
`timescale 1ns/1ps
// self-checking bench for boot decode, both flash sizes side by side
module testbench;
	logic        i_clk = 1'h0;
	logic        i_rst_b = 1'h0;
	logic [1:0]  sel = 2'h0;
	logic [15:0] ptr, bs, ae, bw, wa, bs6, ae6, bw6, wa6;
	logic [16:0] bb, bb6;
	logic [8:0]  pg, pg6;
	logic [6:0]  wd, wd6;
	logic        st, pw, ld, by, ib, sr, cr, sv, sm, pe, lv;
	int          err_count = 0;
	int          checked = 0;
	logic [15:0] s32 [4] = '{16'h3800, 16'h3C00, 16'h3E00, 16'h3F00};
	logic [15:0] s64 [4] = '{16'h7000, 16'h7800, 16'h7C00, 16'h7E00};
	always #4 i_clk = ~i_clk;
	cpu_core_model cpu_core_model_inst (.i_clk, .o_pointer(ptr), .o_store_req(st), .o_page_write(pw), .o_load_req(ld));
	boot_section_address_decode boot_section_address_decode_inst (.i_clk, .i_rst_b, .i_boot_size_sel_hi(sel[1]),
		.i_boot_size_sel_lo(sel[0]), .i_pointer(ptr), .i_store_req(st), .i_page_write(pw), .i_load_req(ld),
		.o_boot_start(bs), .o_app_end(ae), .o_boot_words(bw), .o_boot_bytes(bb), .o_word_addr(wa),
		.o_page_select_field(pg), .o_word_select_field(wd), .o_byte_select(by), .o_in_boot(ib), .o_stalled_read_region(sr),
		.o_concurrent_read_region(cr), .o_store_valid(sv), .o_store_misaligned(sm), .o_page_write_offset_err(pe),
		.o_load_valid(lv));
	boot_section_address_decode #(.VARIANT(boot_decode_pkg::VARIANT_64K)) boot_section_address_decode_inst_64k (.i_clk,
		.i_rst_b, .i_boot_size_sel_hi(sel[1]), .i_boot_size_sel_lo(sel[0]), .i_pointer(ptr), .i_store_req(st),
		.i_page_write(pw), .i_load_req(ld), .o_boot_start(bs6), .o_app_end(ae6), .o_boot_words(bw6), .o_boot_bytes(bb6),
		.o_word_addr(wa6), .o_page_select_field(pg6), .o_word_select_field(wd6), .o_byte_select(), .o_in_boot(),
		.o_stalled_read_region(), .o_concurrent_read_region(), .o_store_valid(), .o_store_misaligned(),
		.o_page_write_offset_err(), .o_load_valid());
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checked %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	// reset with a setting, then move the pins: decode must keep the sampled value
	task automatic t_fuse(input logic [1:0] s);
		i_rst_b = 1'h0;
		sel = s;
		repeat (2) @(posedge i_clk);
		#1 i_rst_b = 1'h1;
		repeat (3) @(posedge i_clk);
		#1 sel = ~s;
		repeat (3) @(posedge i_clk);
		#1;
		chk({bs, ae, bw}, {s32[s], s32[s] - 16'h0001, 16'h4000 - s32[s]});
		chk(bb, {16'h4000 - s32[s], 1'h0});
		chk({bs6, ae6, bw6}, {s64[s], s64[s] - 16'h0001, 16'h8000 - s64[s]});
		chk(bb6, {16'h8000 - s64[s], 1'h0});
		$display("fuse setting %0d done", s);
	endtask : t_fuse
	// one request from the core, judged on the edge that answers it
	task automatic t_map(input logic [15:0] p, input logic s, input logic w, input logic l);
		cpu_core_model_inst.issue(p, s, w, l);
		chk(wa, {2'h0, p[14:1]});
		chk({pg, wd, by}, {1'h0, p[14:7], 1'h0, p[6:1], p[0]});
		chk({ib, sr, cr}, {p[14:1] >= 14'h3F00, p[14:1] >= 14'h3800, p[14:1] < 14'h3800});
		chk({sv, sm, pe, lv}, {s, s & p[0], s & w & (p[6:1] != 6'h00), l});
		chk({wa6, pg6, wd6}, {1'h0, p[15:1], p[15:7], p[7:1]});
		$display("pointer %h done", p);
	endtask : t_map
	initial begin
		for (int i = 0; i < 4; i++) t_fuse(i[1:0]);
		t_map(16'h7002, 1'h1, 1'h1, 1'h0);
		t_map(16'h6FFF, 1'h0, 1'h0, 1'h1);
		t_map(16'hFFFF, 1'h1, 1'h0, 1'h0);
		t_map(16'h7E00, 1'h1, 1'h1, 1'h0);
		t_map(16'h7DFE, 1'h1, 1'h0, 1'h1);
		cpu_core_model_inst.issue(16'h0000, 1'h0, 1'h0, 1'h0);
		end_sim;
	end
	// about 40 cycles of work; a hang is cut off well after
	initial begin
		#5000;
		err_count++;
		end_sim;
	end
endmodule : testbench
